// [hdl/flash_read_opts.v]
// Read-path options: wrap addressing, learning pattern, dummy count
// Operation
// - Wrap confines burst to aligned block
// - Wrap counts up then restarts at zero
// - Select bit one: same pattern all lines
// - Select bit zero: line three inverted
// - Host-written pattern becomes training data
// - Pattern shifted out most significant first
// - Pattern resets to 55h, no inversion
// - Dummy codes 1..30; 00h,1Fh give default
`timescale 1ns/10ps
`include "flash_read_opts_defines.vh"
module flash_read_opts #(
   parameter DEPTH = 4
) (
   input  wire       clk_i,
   input  wire       srst_i,
   input  wire       link_clk_i,     // Serial clock from host
   input  wire       cs_n_i,         // Chip select, active low
   input  wire       cfg_we_i,       // Config write strobe
   input  wire [7:0] cfg_addr_i,     // Config byte address
   input  wire [7:0] cfg_wdata_i,    // Config write data
   output reg  [7:0] cfg_rdata_o,    // Config read data
   input  wire       read_start_i,   // Starts an array read burst
   input  wire [5:0] start_addr_i,   // Low start address bits
   input  wire       train_start_i,  // Starts a pattern burst
   output wire [4:0] dummy_cycles_o, // Effective dummy count
   output reg  [5:0] byte_addr_o,    // Array byte address to fetch
   input  wire [7:0] array_data_i,   // Byte at byte_addr_o
   output reg  [7:0] dq_o,           // Data lines out
   output reg        dq_oe_o,        // Data lines driven
   output reg        busy_o          // Burst in progress
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_ARRAY = 2'h1;
   localparam ST_TRAIN = 2'h2;

   reg  [7:0] learning_pattern_r;    // Training byte
   reg  [7:0] switch_cfg_r;          // Byte holding switching_pattern_select
   reg  [7:0] dummy_cfg_r;           // Dummy cycle code
   reg  [4:0] dummy_cycles_r;        // Decoded dummy count
   wire       flush_w;               // Drops prefetched beats at array burst end
   reg  [1:0] wrap_cfg_r;            // Wrap size
   reg  [1:0] state_r;               // Burst state
   reg  [5:0] offs_r;                // Offset within wrap block
   reg  [5:0] base_r;                // Aligned block base
   reg  [2:0] bit_r;                 // Training bit index
   reg        clk_m_r;               // Sync stage one
   reg        clk_s_r;               // Sync stage two
   reg        clk_d_r;               // Previous synced clock
   reg        cs_m_r;                // Chip select sync one
   reg        cs_s_r;                // Chip select sync two
   wire       edge_w;                // Falling link clock edge
   wire       switching_pattern_select;
   wire [5:0] mask_w;
   wire [7:0] fifo_data;
   wire       fifo_valid;
   wire       fifo_ready;
   reg  [7:0] src_data;
   reg        src_valid;

   // Block mask from wrap size; no wrap behaves as a 64-byte window
   function [5:0] wrap_mask;
      input [1:0] sel;
      begin
         case (sel)
            `WRAP_16: wrap_mask = `MASK_16;
            `WRAP_32: wrap_mask = `MASK_32;
            default:  wrap_mask = `MASK_64;
         endcase
      end
   endfunction

   // Training beat: same bit on all lines, line three optionally inverted
   function [7:0] train_beat;
      input b;
      input sel;
      begin
         train_beat = {8{b}};
         if (!sel) begin
            train_beat[`DATA_LINE_THREE] = ~b;
         end
      end
   endfunction

   // Dummy code to cycle count; zero and codes past 30 fall back to default
   function [4:0] dummy_decode;
      input [7:0] code;
      begin
         if (code == `DUMMY_CODE_ZERO || code > `DUMMY_CODE_MAX) begin
            dummy_decode = `DUMMY_DEFAULT_CYCLES;
         end else begin
            dummy_decode = code[4:0];
         end
      end
   endfunction

   assign switching_pattern_select = switch_cfg_r[`SWITCH_SEL_BIT];
   assign mask_w = wrap_mask(wrap_cfg_r);
   assign edge_w = clk_d_r & ~clk_s_r;
   // Host must pick a count suited to its clock; we only report it
   assign dummy_cycles_o = dummy_cycles_r;
   // Leftover prefetch must not leak into the next burst
   assign flush_w = (state_r == ST_ARRAY) & ~read_start_i & cs_s_r;

   ////////////////////////////////////////////////////////////////
   // Synchronise link clock and chip select
   always @(posedge clk_i) begin
      if (srst_i) begin
         clk_m_r <= 1'b0;
         clk_s_r <= 1'b0;
         clk_d_r <= 1'b0;
         cs_m_r  <= 1'b1;
         cs_s_r  <= 1'b1;
      end else begin
         clk_m_r <= link_clk_i;
         clk_s_r <= clk_m_r;
         clk_d_r <= clk_s_r;
         cs_m_r  <= cs_n_i;
         cs_s_r  <= cs_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Configuration bytes; the dummy count is decoded as it is written
   always @(posedge clk_i) begin
      if (srst_i) begin
         learning_pattern_r <= `PATTERN_RESET;
         switch_cfg_r       <= `SWITCH_RESET;
         dummy_cfg_r        <= `DUMMY_RESET;
         dummy_cycles_r     <= `DUMMY_DEFAULT_CYCLES;
         wrap_cfg_r         <= `WRAP_RESET;
      end else if (cfg_we_i) begin
         case (cfg_addr_i)
            `CFG_ADDR_PATTERN: learning_pattern_r <= cfg_wdata_i;
            `CFG_ADDR_SWITCH:  switch_cfg_r       <= cfg_wdata_i;
            `CFG_ADDR_DUMMY: begin
               dummy_cfg_r    <= cfg_wdata_i;
               dummy_cycles_r <= dummy_decode(cfg_wdata_i);
            end
            `CFG_ADDR_WRAP:    wrap_cfg_r         <= cfg_wdata_i[1:0];
            default:           ;                                 // Unmapped ignored
         endcase
      end
   end

   // Registered read back, one clock behind the address; unmapped read zero
   always @(posedge clk_i) begin
      if (srst_i) begin
         cfg_rdata_o <= 8'h00;
      end else begin
         case (cfg_addr_i)
            `CFG_ADDR_PATTERN: cfg_rdata_o <= learning_pattern_r;
            `CFG_ADDR_SWITCH:  cfg_rdata_o <= switch_cfg_r;
            `CFG_ADDR_DUMMY:   cfg_rdata_o <= dummy_cfg_r;
            `CFG_ADDR_WRAP:    cfg_rdata_o <= {6'h00, wrap_cfg_r};
            default:           cfg_rdata_o <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Burst sequencer; a beat is produced only when the FIFO has room
   always @(posedge clk_i) begin
      if (srst_i) begin
         state_r     <= ST_IDLE;
         offs_r      <= 6'h00;
         base_r      <= 6'h00;
         bit_r       <= `TRAIN_FIRST_BIT;
         byte_addr_o <= 6'h00;
         busy_o      <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               busy_o <= 1'b0;
               if (read_start_i) begin
                  // Aligned block base, offset inside it
                  base_r      <= start_addr_i & ~mask_w;
                  offs_r      <= start_addr_i & mask_w;
                  byte_addr_o <= start_addr_i;
                  busy_o      <= 1'b1;
                  state_r     <= ST_ARRAY;
               end else if (train_start_i) begin
                  bit_r   <= `TRAIN_FIRST_BIT;
                  busy_o  <= 1'b1;
                  state_r <= ST_TRAIN;
               end
            end
            ST_ARRAY: begin
               if (read_start_i == 1'b0 && cs_s_r) begin
                  state_r <= ST_IDLE;
               end else if (fifo_ready) begin
                  // Past the last byte the offset returns to zero
                  offs_r      <= (offs_r + 6'h01) & mask_w;
                  byte_addr_o <= base_r | ((offs_r + 6'h01) & mask_w);
               end
            end
            ST_TRAIN: begin
               if (fifo_ready) begin
                  bit_r <= bit_r - 3'h1;
                  if (bit_r == 3'h0) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Beat source feeding the FIFO
   always @* begin
      src_valid = 1'b0;
      src_data  = 8'h00;
      case (state_r)
         ST_ARRAY: begin
            src_valid = ~(read_start_i == 1'b0 && cs_s_r);
            src_data  = array_data_i;
         end
         ST_TRAIN: begin
            src_valid = 1'b1;
            src_data  = train_beat(learning_pattern_r[bit_r],
                                   switching_pattern_select);
         end
         default: ;
      endcase
   end

   sample_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH),
      .AW    (2)
   ) u_fifo (
      .clk_i       (clk_i),
      .srst_i      (srst_i | flush_w),
      .in_data_i   (src_data),
      .in_valid_i  (src_valid),
      .in_ready_o  (fifo_ready),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (edge_w & ~cs_s_r)
   );

   ////////////////////////////////////////////////////////////////
   // Drive a beat per falling link clock edge while selected
   always @(posedge clk_i) begin
      if (srst_i) begin
         dq_o    <= 8'h00;
         dq_oe_o <= 1'b0;
      end else begin
         dq_oe_o <= ~cs_s_r;
         if (edge_w & ~cs_s_r & fifo_valid) begin
            dq_o <= fifo_data;
         end
      end
   end
endmodule // flash_read_opts

// [hdl/flash_read_opts_defines.vh]
// Constants for the octal flash read-option block
`ifndef FLASH_READ_OPTS_DEFINES_VH
`define FLASH_READ_OPTS_DEFINES_VH
`define CFG_ADDR_PATTERN     8'h0a
`define CFG_ADDR_SWITCH      8'h0b
`define CFG_ADDR_DUMMY       8'h01
`define CFG_ADDR_WRAP        8'h02
`define PATTERN_RESET        8'h55
`define SWITCH_SEL_BIT       6
`define SWITCH_RESET         8'hff
`define DUMMY_RESET          8'h1f
`define DUMMY_CODE_ZERO      8'h00
`define TRAIN_FIRST_BIT      3'h7
`define DUMMY_CODE_MAX       8'h1e
`define DUMMY_DEFAULT_CYCLES 5'h10
`define WRAP_RESET           2'h0
`define WRAP_NONE            2'h0
`define WRAP_16              2'h1
`define WRAP_32              2'h2
`define WRAP_64              2'h3
`define MASK_16              6'h0f
`define MASK_32              6'h1f
`define MASK_64              6'h3f
`define DATA_LINE_THREE      3
`endif

// [hdl/sample_fifo.v]
// Small valid/ready FIFO used on the read data path
`timescale 1ns/10ps
module sample_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk_i,
   input  wire             srst_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // Storage
   reg [AW-1:0]    wp_r;              // Write pointer
   reg [AW-1:0]    rp_r;              // Read pointer
   reg [AW:0]      cnt_r;             // Fill level
   wire            push;
   wire            pop;
   assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
   assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
   assign out_data_o  = mem_r[rp_r];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;
   ////////////////////////////////////////////////////////////////
   // Pointers and level
   always @(posedge clk_i) begin
      if (srst_i) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data_i;
            wp_r        <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         // Simultaneous push and pop keeps the level
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // sample_fifo

// [sim/flash_read_opts_properties.sv]
// Port-level checks for the read-option block
`timescale 1ns/10ps
module flash_read_opts_properties #(
   parameter DEPTH = 4
) (
   input wire       clk_i,
   input wire       srst_i,
   input wire       cfg_we_i,
   input wire [7:0] cfg_addr_i,
   input wire [7:0] cfg_wdata_i,
   input wire [7:0] cfg_rdata_o,
   input wire       read_start_i,
   input wire       train_start_i,
   input wire [4:0] dummy_cycles_o,
   input wire [5:0] byte_addr_o,
   input wire [7:0] dq_o,
   input wire       busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   reg       sel_r;  // Shadow of line-three select bit
   reg       trn_r;  // Last start seen while busy_o low was training; training wins a tie
   reg [1:0] wrap_r; // Shadow of wrap mode
   ////////////////////////////////////////////////////////////
   // Shadows let checks know the mode without seeing the body
   always @(posedge clk_i) begin
      if (srst_i) begin
         sel_r <= 1'b1;
         trn_r <= 1'b0;
         wrap_r <= 2'h0;
      end else begin
         if (cfg_we_i && cfg_addr_i == 8'h0b)
            sel_r <= cfg_wdata_i[6];
         if (cfg_we_i && cfg_addr_i == 8'h02)
            wrap_r <= cfg_wdata_i[1:0];
         if (!busy_o && train_start_i)
            trn_r <= 1'b1;
         else if (!busy_o && read_start_i)
            trn_r <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////
   AST_DUMMY_SET: assert property (cfg_we_i && cfg_addr_i == 8'h01 && cfg_wdata_i != 8'h00
      && cfg_wdata_i < 8'h1f |=> dummy_cycles_o == $past(cfg_wdata_i[4:0]))
      else $error("dummy count differs from code");
   AST_DUMMY_DEF: assert property (cfg_we_i && cfg_addr_i == 8'h01
      && (cfg_wdata_i == 8'h00 || cfg_wdata_i == 8'h1f) |=> dummy_cycles_o == 5'h10)
      else $error("default dummy count wrong");
   AST_PAT_RESET: assert property ($fell(srst_i) && cfg_addr_i == 8'h0a |=>
      cfg_rdata_o == 8'h55) else $error("pattern reset value wrong");
   AST_PAT_BACK: assert property (cfg_we_i && cfg_addr_i == 8'h0a ##1 cfg_addr_i == 8'h0a
      |=> cfg_rdata_o == $past(cfg_wdata_i, 2)) else $error("pattern readback wrong");
   AST_TRAIN_SAME: assert property (trn_r && sel_r && busy_o && $changed(dq_o) |->
      dq_o == 8'h00 || dq_o == 8'hff) else $error("lines differ in training");
   AST_TRAIN_INV: assert property (trn_r && !sel_r && busy_o && $changed(dq_o) |->
      dq_o == 8'h08 || dq_o == 8'hf7) else $error("line three not inverted");
   AST_WRAP_STEP: assert property (!trn_r && wrap_r == 2'h1 && busy_o && $past(busy_o)
      && $changed(byte_addr_o) |-> byte_addr_o[5:4] == $past(byte_addr_o[5:4])
      && byte_addr_o[3:0] == $past(byte_addr_o[3:0]) + 4'h1) else $error("16 wrap step wrong");
   AST_WRAP_BLOCK: assert property (!trn_r && wrap_r == 2'h2 && busy_o && $past(busy_o)
      |-> $stable(byte_addr_o[5])) else $error("32 wrap left its block");
   // Main scenarios reached
   cover property (train_start_i && !busy_o);
   cover property (!trn_r && wrap_r == 2'h1 && busy_o && byte_addr_o == 6'h00);
   cover property (trn_r && !sel_r && busy_o);
endmodule // flash_read_opts_properties

// [sim/flash_host_model.sv]
// Host controller and array model on the far side of the block
`timescale 1ns/10ps
module flash_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] dq_i,
   input  wire logic [5:0] addr_i,
   output logic            link_clk_o,
   output logic            cs_n_o,
   output logic [7:0]      array_o
);
   logic [7:0] beats [0:31]; // Beats taken, one per falling link edge
   // Each array byte holds its own address, so order shows
   assign array_o = {2'h0, addr_i};
   initial begin
      link_clk_o = 1'b0;
      cs_n_o = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // Link clock runs only inside a frame, 400 ns period; dummy
   // count is kept low by the bench so this pace stays legal
   task automatic burst(input int n);
      @(negedge clk_i);
      cs_n_o = 1'b0;
      repeat (8) @(negedge clk_i);
      for (int i = 0; i <= n; i++) begin
         link_clk_o = 1'b1;
         repeat (4) @(negedge clk_i);
         // Eight clocks after the fall, well past the answer delay
         if (i > 0)
            beats[i-1] = dq_i;
         link_clk_o = 1'b0;
         repeat (4) @(negedge clk_i);
      end
      cs_n_o = 1'b1;
   endtask
endmodule // flash_host_model

// [sim/tb_top.sv]
// Self-checking bench for the read-option block
`timescale 1ns/10ps
module tb_top;
   logic       clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       cfg_we = 1'b0;
   logic [7:0] cfg_addr = 8'h0a;
   logic [7:0] cfg_wdata = 8'h00;
   logic       read_start = 1'b0;
   logic       train_start = 1'b0;
   logic [5:0] start_addr = 6'h00;
   logic       link_clk, cs_n, dq_oe, busy;
   logic [7:0] cfg_rdata, array_data, dq;
   logic [4:0] dummy;
   logic [5:0] byte_addr;
   int         n_fail = 0;
   int         n_checks = 0;
   int         cyc = 0;
   always #25 clk_i = ~clk_i;
   flash_read_opts #(.DEPTH(4)) DUT (.clk_i(clk_i), .srst_i(srst_i), .link_clk_i(link_clk),
      .cs_n_i(cs_n), .cfg_we_i(cfg_we), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata),
      .cfg_rdata_o(cfg_rdata), .read_start_i(read_start), .start_addr_i(start_addr),
      .train_start_i(train_start), .dummy_cycles_o(dummy), .byte_addr_o(byte_addr),
      .array_data_i(array_data), .dq_o(dq), .dq_oe_o(dq_oe), .busy_o(busy));
   flash_host_model HOST (.clk_i(clk_i), .dq_i(dq), .addr_i(byte_addr),
      .link_clk_o(link_clk), .cs_n_o(cs_n), .array_o(array_data));
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // A hang counts as a mismatch
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      cfg_we = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge clk_i);
      cfg_we = 1'b0;
   endtask
   // Read data is registered, so look one clock after the address
   task automatic cfg_at(input logic [7:0] a);
      @(negedge clk_i);
      cfg_addr = a;
      @(negedge clk_i);
   endtask
   // Bounded wait for the burst to wind down, then lines released
   task automatic wait_idle;
      repeat (3) @(negedge clk_i);
      for (int i = 0; i < 200 && busy !== 1'b0; i++)
         @(negedge clk_i);
      check({7'h00, busy}, 8'h00);
      check({7'h00, dq_oe}, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      cfg_at(8'h0a);
      check(cfg_rdata, 8'h55);
      cfg_at(8'h0b);
      check({1'b0, cfg_rdata[6], 6'h0}, 8'h40);
      check({3'h0, dummy}, 8'h10);
      cfg_wr(8'h30, 8'ha5);
      cfg_at(8'h0a);
      check(cfg_rdata, 8'h55);
   endtask
   // Boundary codes; ends on one dummy so reads stay short
   task automatic t_dummy;
      logic [7:0] c [5] = '{8'h00, 8'h05, 8'h1e, 8'h1f, 8'h01};
      logic [7:0] e [5] = '{8'h10, 8'h05, 8'h1e, 8'h10, 8'h01};
      for (int i = 0; i < 5; i++) begin
         cfg_wr(8'h01, c[i]);
         @(negedge clk_i);
         check({3'h0, dummy}, e[i]);
      end
   endtask
   task automatic t_train(input logic [7:0] p, input logic s, input logic wr);
      logic [7:0] e;
      if (wr) begin
         cfg_wr(8'h0a, p);
         cfg_at(8'h0a);
         check(cfg_rdata, p);
         cfg_wr(8'h0b, {1'b1, s, 6'h3f});
      end
      @(negedge clk_i);
      train_start = 1'b1;
      @(negedge clk_i);
      train_start = 1'b0;
      HOST.burst(8);
      for (int i = 0; i < 8; i++) begin
         e = {8{p[7-i]}} ^ {4'h0, ~s, 3'h0};
         check(HOST.beats[i], e);
      end
      wait_idle();
   endtask
   // First beat is the start byte, then the wrap block is followed
   task automatic t_wrap(input logic [1:0] w, input logic [5:0] m, input logic [5:0] st);
      cfg_wr(8'h02, {6'h0, w});
      @(negedge clk_i);
      start_addr = st;
      read_start = 1'b1;
      HOST.burst(24);
      read_start = 1'b0;
      for (int j = 0; j < 24; j++)
         check(HOST.beats[j], {2'h0, (st & ~m) | ((st + j[5:0]) & m)});
      wait_idle();
   endtask
   initial begin
      repeat (16) @(negedge clk_i);
      srst_i = 1'b0;
      t_reset();
      t_dummy();
      t_train(8'h55, 1'b1, 1'b0);
      t_train(8'h35, 1'b0, 1'b1);
      t_train(8'hca, 1'b1, 1'b1);
      t_wrap(2'h1, 6'h0f, 6'h0e);
      t_wrap(2'h2, 6'h1f, 6'h1e);
      t_wrap(2'h3, 6'h3f, 6'h3e);
      conclude();
   end
endmodule // tb_top
bind flash_read_opts flash_read_opts_properties #(.DEPTH(DEPTH)) CHK (.clk_i(clk_i),
   .srst_i(srst_i), .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
   .cfg_rdata_o(cfg_rdata_o), .read_start_i(read_start_i), .train_start_i(train_start_i),
   .dummy_cycles_o(dummy_cycles_o), .byte_addr_o(byte_addr_o), .dq_o(dq_o), .busy_o(busy_o));
